// ### rtl/spfs_defines.vh
// constants of the sparse pixel frame serializer
`ifndef SPFS_DEFINES_VH
`define SPFS_DEFINES_VH
// ==========================================================
// register byte addresses
`define SPFS_ADDR_CTRL      12'h000
`define SPFS_ADDR_START_WD  12'h004
`define SPFS_ADDR_END_WD    12'h008
`define SPFS_ADDR_FCOUNT    12'h00c
`define SPFS_ADDR_STATUS    12'h010
`define SPFS_ADDR_CLAMP     12'h014
`define SPFS_ADDR_BIAS0     12'h040
`define SPFS_BIAS_COUNT     18
// ==========================================================
// control fields
`define SPFS_CTRL_FAST      0
`define SPFS_CTRL_DUAL      1
`define SPFS_CTRL_RESTART   2
`define SPFS_CTRL_ANATEST   3
`define SPFS_CTRL_RST       4'h0
// ==========================================================
// timing
`define SPFS_CLK_NS         8
`define SPFS_FRAME_NS       185600
`define SPFS_HALF_FAST      2'h1
`define SPFS_HALF_SLOW      2'h2
`define SPFS_MARK_BITS      4'h3
// ==========================================================
// frame layout, per line slot counts
`define SPFS_CAP_M80        12'h1cb
`define SPFS_CAP_D80        12'h396
`define SPFS_CAP_M160       12'h39a
`define SPFS_CAP_D160       12'h73a
`define SPFS_BANK_WORDS     13'h1000
`endif

// ### rtl/spfs_serializer.v
// sparse pixel frame serializer: apb registers, double buffer, serial framer
//
// Functional notes
// - output clock toggles whenever ce is high, also after the frame data is sent.
// - rate select picks fast or slow output clock.
// - rate select and dual select give four output configurations.
// - each 16-bit word goes out lsb first; receiver assembles alike.
// - frame order: header, frame count, length, useful words, trailer.
// - 32-bit fields split into low part 0 and high part 1.
// - marker high for exactly four rising output clock edges at frame start.
// - start and end words are fully programmable and independent.
// - 32-bit frame counter counts frames and wraps to zero.
// - restart bit written one then zero clears the frame counter.
// - counter low half on line zero, high half on line one in dual mode; single line sends both halves on line one.
// - length field gives half the number of 16-bit useful words, rounded up and capped per mode.
// - single line repeats per-half count twice; receiver adds both halves.
// - frame without hits sends zero in both length halves.
// - previous frame's words go out while current frame is captured.
// - two serial data lines plus output clock and marker.
// - start input reinitialises the readout sequence.
// - bias holds eighteen 8-bit codes and one 4-bit clamp code.
// - analogue test output enabled only while its bit is one.
// - constant frame period; unused slots after trailer are zero.
// - odd word count pads line one with a dummy word.
`timescale 1ns/1ns
`default_nettype none
`include "spfs_defines.vh"

module spfs_serializer #(
  parameter FRAME_CYCLES = `SPFS_FRAME_NS / `SPFS_CLK_NS
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  input  wire         startIn,
  input  wire         hitValid,
  input  wire [15:0]  hitWord,
  output reg          serialClk,
  output reg          serialLineZero,
  output reg          serialLineOne,
  output reg          frameMarker,
  output reg  [143:0] biasCodes,
  output reg  [3:0]   pixelClampDac,
  output reg          analogueTestEn
);

  localparam ST_WAIT = 2'b01;
  localparam ST_RUN  = 2'b10;

  // ==========================================================
  // registers
  reg  [3:0]  ctrl_reg;
  reg  [31:0] startWord_reg;
  reg  [31:0] endWord_reg;
  reg  [31:0] frameCnt_reg;
  reg         restartPrev_reg;
  reg  [7:0]  bias_reg [0:`SPFS_BIAS_COUNT-1];
  reg  [31:0] rdData_next;
  reg         rdErr_next;
  wire        apbSetup = psel && !penable;
  wire        apbWrite = psel && penable && pwrite && pready;
  integer     bi;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg      <= `SPFS_CTRL_RST;
      startWord_reg <= 32'h0;
      endWord_reg   <= 32'h0;
      pixelClampDac <= 4'h0;
      pready        <= 1'b0;
      prdata        <= 32'h0;
      pslverr       <= 1'b0;
    end else if (ce) begin
      // no wait state: ready rises in the first access cycle
      pready  <= apbSetup;
      prdata  <= (apbSetup && !pwrite) ? rdData_next : 32'h0;
      pslverr <= apbSetup && rdErr_next;
      if (apbWrite) begin
        case (paddr)
          `SPFS_ADDR_CTRL:     ctrl_reg      <= pwdata[3:0];
          `SPFS_ADDR_START_WD: startWord_reg <= pwdata;
          `SPFS_ADDR_END_WD:   endWord_reg   <= pwdata;
          `SPFS_ADDR_CLAMP:    pixelClampDac <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SPFS_BIAS_COUNT; gi = gi + 1) begin : gBias
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          bias_reg[gi] <= 8'h0;
        end else if (ce && apbWrite && paddr == `SPFS_ADDR_BIAS0 + gi * 4) begin
          bias_reg[gi] <= pwdata[7:0];
        end
      end
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          biasCodes[gi*8 +: 8] <= 8'h0;
        end else if (ce) begin
          biasCodes[gi*8 +: 8] <= bias_reg[gi];
        end
      end
    end
  endgenerate

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      analogueTestEn <= 1'b0;
    end else if (ce) begin
      analogueTestEn <= ctrl_reg[`SPFS_CTRL_ANATEST];
    end
  end

  // ==========================================================
  // start synchroniser
  reg  startSync1_reg;
  reg  startSync2_reg;
  reg  startSync3_reg;
  wire startRise = startSync2_reg && !startSync3_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      startSync1_reg <= 1'b0;
      startSync2_reg <= 1'b0;
      startSync3_reg <= 1'b0;
    end else if (ce) begin
      startSync1_reg <= startIn;
      startSync2_reg <= startSync1_reg;
      startSync3_reg <= startSync2_reg;
    end
  end

  // ==========================================================
  // frame timer and double buffer
  reg  [1:0]  state_reg;
  reg  [31:0] frameTimer_reg;
  reg         acqBank_reg;
  reg  [12:0] wrCnt_reg;
  reg  [12:0] sendCnt_reg;
  reg  [31:0] cntSent_reg;
  reg         framePend_reg;
  reg  [15:0] mem [0:8191];
  wire        hitTake  = hitValid && (wrCnt_reg < `SPFS_BANK_WORDS);
  wire [12:0] effCnt   = wrCnt_reg + {12'h0, hitTake};
  wire        timerEnd = (state_reg == ST_RUN) && (frameTimer_reg == FRAME_CYCLES - 1);
  wire        frameBoundary = startRise || timerEnd;
  wire        bitAdvance;

  always @(posedge clk) begin
    if (ce && hitTake) begin
      mem[{acqBank_reg, wrCnt_reg[11:0]}] <= hitWord;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg       <= ST_WAIT;
      frameTimer_reg  <= 32'h0;
      acqBank_reg     <= 1'b0;
      wrCnt_reg       <= 13'h0;
      sendCnt_reg     <= 13'h0;
      cntSent_reg     <= 32'h0;
      frameCnt_reg    <= 32'h0;
      restartPrev_reg <= 1'b0;
      framePend_reg   <= 1'b0;
    end else if (ce) begin
      restartPrev_reg <= ctrl_reg[`SPFS_CTRL_RESTART];
      if (frameBoundary) begin
        state_reg      <= ST_RUN;
        frameTimer_reg <= 32'h0;
        acqBank_reg    <= ~acqBank_reg;
        sendCnt_reg    <= effCnt;
        wrCnt_reg      <= 13'h0;
        cntSent_reg    <= frameCnt_reg;
        framePend_reg  <= 1'b1;
      end else begin
        if (state_reg == ST_RUN) begin
          frameTimer_reg <= frameTimer_reg + 32'h1;
        end
        wrCnt_reg <= effCnt;
        if (bitAdvance) begin
          framePend_reg <= 1'b0;
        end
      end
      // clear on the falling edge of the restart bit wins over counting
      if (restartPrev_reg && !ctrl_reg[`SPFS_CTRL_RESTART]) begin
        frameCnt_reg <= 32'h0;
      end else if (frameBoundary) begin
        frameCnt_reg <= frameCnt_reg + 32'h1;
      end
    end
  end

  // ==========================================================
  // output clock divider
  reg  [1:0] halfCnt_reg;
  wire [1:0] halfLen = ctrl_reg[`SPFS_CTRL_FAST] ? `SPFS_HALF_FAST : `SPFS_HALF_SLOW;
  wire       halfWrap = (halfCnt_reg >= halfLen - 2'h1);
  assign bitAdvance = halfWrap && serialClk;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      halfCnt_reg <= 2'h0;
      serialClk   <= 1'b0;
    end else if (ce) begin
      if (halfWrap) begin
        halfCnt_reg <= 2'h0;
        serialClk   <= ~serialClk;
      end else begin
        halfCnt_reg <= halfCnt_reg + 2'h1;
      end
    end
  end

  // ==========================================================
  // slot contents
  reg  [15:0] slot_reg;
  reg  [3:0]  bitCnt_reg;
  reg  [15:0] shift0_reg;
  reg  [15:0] shift1_reg;
  reg  [15:0] nextSlot;
  reg  [15:0] word0_next;
  reg  [15:0] word1_next;
  reg  [11:0] cap;
  reg  [11:0] perLine;
  reg  [12:0] half;
  reg  [15:0] dIdx;
  wire        dual = ctrl_reg[`SPFS_CTRL_DUAL];
  wire        sendBank = ~acqBank_reg;

  always @* begin
    nextSlot = framePend_reg ? 16'h0 :
               ((slot_reg == 16'hffff) ? slot_reg : slot_reg + 16'h1);
    case ({ctrl_reg[`SPFS_CTRL_FAST], dual})
      2'b00:   cap = `SPFS_CAP_M80;
      2'b01:   cap = `SPFS_CAP_D80;
      2'b10:   cap = `SPFS_CAP_M160;
      default: cap = `SPFS_CAP_D160;
    endcase
    half    = (sendCnt_reg + 13'h1) >> 1;
    perLine = (half > {1'b0, cap}) ? cap : half[11:0];
    word0_next = 16'h0;
    word1_next = 16'h0;
    dIdx       = 16'h0;
    if (dual) begin
      case (nextSlot)
        16'h0: begin
          word0_next = startWord_reg[15:0];
          word1_next = startWord_reg[31:16];
        end
        16'h1: begin
          word0_next = cntSent_reg[15:0];
          word1_next = cntSent_reg[31:16];
        end
        16'h2: begin
          word0_next = {4'h0, perLine};
          word1_next = {4'h0, perLine};
        end
        default: begin
          if (nextSlot - 16'h3 < {4'h0, perLine}) begin
            dIdx       = (nextSlot - 16'h3) << 1;
            word0_next = (dIdx < {3'h0, sendCnt_reg}) ?
                         mem[{sendBank, dIdx[11:0]}] : 16'h0;
            word1_next = (dIdx + 16'h1 < {3'h0, sendCnt_reg}) ?
                         mem[{sendBank, dIdx[11:0] + 12'h1}] : 16'h0;
          end else if (nextSlot - 16'h3 == {4'h0, perLine}) begin
            word0_next = endWord_reg[15:0];
            word1_next = endWord_reg[31:16];
          end
        end
      endcase
    end else begin
      // single line: everything on line one, low part first
      case (nextSlot)
        16'h0:   word1_next = startWord_reg[15:0];
        16'h1:   word1_next = startWord_reg[31:16];
        16'h2:   word1_next = cntSent_reg[15:0];
        16'h3:   word1_next = cntSent_reg[31:16];
        16'h4:   word1_next = {4'h0, perLine};
        16'h5:   word1_next = {4'h0, perLine};
        default: begin
          dIdx = nextSlot - 16'h6;
          if (dIdx < {3'h0, perLine, 1'b0}) begin
            word1_next = (dIdx < {3'h0, sendCnt_reg}) ?
                         mem[{sendBank, dIdx[11:0]}] : 16'h0;
          end else if (dIdx == {3'h0, perLine, 1'b0}) begin
            word1_next = endWord_reg[15:0];
          end else if (dIdx == {3'h0, perLine, 1'b0} + 16'h1) begin
            word1_next = endWord_reg[31:16];
          end
        end
      endcase
    end
  end

  // ==========================================================
  // shifter and marker
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_reg       <= 16'hffff;
      bitCnt_reg     <= 4'h0;
      shift0_reg     <= 16'h0;
      shift1_reg     <= 16'h0;
      serialLineZero <= 1'b0;
      serialLineOne  <= 1'b0;
      frameMarker    <= 1'b0;
    end else if (ce && bitAdvance) begin
      if (framePend_reg || bitCnt_reg == 4'hf) begin
        slot_reg       <= nextSlot;
        bitCnt_reg     <= 4'h0;
        shift0_reg     <= {1'b0, word0_next[15:1]};
        shift1_reg     <= {1'b0, word1_next[15:1]};
        serialLineZero <= word0_next[0];
        serialLineOne  <= word1_next[0];
        frameMarker    <= framePend_reg;
      end else begin
        bitCnt_reg     <= bitCnt_reg + 4'h1;
        shift0_reg     <= {1'b0, shift0_reg[15:1]};
        shift1_reg     <= {1'b0, shift1_reg[15:1]};
        serialLineZero <= shift0_reg[0];
        serialLineOne  <= shift1_reg[0];
        frameMarker    <= (slot_reg == 16'h0) && (bitCnt_reg < `SPFS_MARK_BITS);
      end
    end
  end

  // ==========================================================
  // apb read mux
  always @* begin
    rdData_next = 32'h0;
    rdErr_next  = 1'b0;
    for (bi = 0; bi < `SPFS_BIAS_COUNT; bi = bi + 1) begin
      if (paddr == `SPFS_ADDR_BIAS0 + bi * 4) begin
        rdData_next = {24'h0, bias_reg[bi]};
      end
    end
    case (paddr)
      `SPFS_ADDR_CTRL:     rdData_next = {28'h0, ctrl_reg};
      `SPFS_ADDR_START_WD: rdData_next = startWord_reg;
      `SPFS_ADDR_END_WD:   rdData_next = endWord_reg;
      `SPFS_ADDR_FCOUNT:   rdData_next = frameCnt_reg;
      `SPFS_ADDR_STATUS:   rdData_next = {17'h0, acqBank_reg, state_reg == ST_RUN, sendCnt_reg};
      `SPFS_ADDR_CLAMP:    rdData_next = {28'h0, pixelClampDac};
      default: begin
        if (paddr[1:0] != 2'h0 || paddr < `SPFS_ADDR_BIAS0 ||
            paddr > `SPFS_ADDR_BIAS0 + (`SPFS_BIAS_COUNT - 1) * 4) begin
          rdErr_next = 1'b1;
        end
      end
    endcase
  end

endmodule // spfs_serializer
`default_nettype wire

// ### test/spfs_rx_model.sv
// passive receiver model of the serial frame link
`timescale 1ns/1ns
`default_nettype none
module spfs_rx_model (
  input  wire logic        serialClk,
  input  wire logic        serialLineZero,
  input  wire logic        serialLineOne,
  input  wire logic        frameMarker,
  output var  logic [15:0] wordsZero [0:15],
  output var  logic [15:0] wordsOne [0:15],
  output var  logic [4:0]  wordCount,
  output var  logic [7:0]  frameCount
);
  logic        markPrev;
  logic [3:0]  bitIdx;
  logic [15:0] shZero;
  logic [15:0] shOne;
  initial begin
    markPrev = 1'b0;
    bitIdx = 4'h0;
    wordCount = 5'h0;
    frameCount = 8'h0;
    shZero = 16'h0;
    shOne = 16'h0;
  end
  // ====
  // sampling on the rising output clock
  always @(posedge serialClk) begin
    if (frameMarker && !markPrev) begin
      frameCount = frameCount + 8'h1;
      wordCount = 5'h0;
      bitIdx = 4'h0;
    end
    markPrev = frameMarker;
    // lsb arrives first, so bits enter at the top
    shZero = {serialLineZero, shZero[15:1]};
    shOne = {serialLineOne, shOne[15:1]};
    // only the first sixteen words are kept; later ones are dropped and not counted
    if (bitIdx == 4'hf && wordCount < 5'h10) begin
      wordsZero[wordCount[3:0]] = shZero;
      wordsOne[wordCount[3:0]] = shOne;
      wordCount = wordCount + 5'h1;
    end
    bitIdx = bitIdx + 4'h1;
  end
endmodule // spfs_rx_model
`default_nettype wire

// ### test/spfs_serializer_sva.sv
// checker of the sparse pixel frame serializer ports
`timescale 1ns/1ns
`default_nettype none
module spfs_checker (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         ce,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         serialClk,
  input wire logic         serialLineZero,
  input wire logic         serialLineOne,
  input wire logic         frameMarker,
  input wire logic [143:0] biasCodes,
  input wire logic         analogueTestEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // helper logic
  logic       sclkPrev_reg;
  logic [2:0] markRise_reg;
  logic [2:0] markRise_next;
  logic       mapped;
  assign mapped = (paddr[1:0] == 2'h0) && ((paddr < 12'h018) ||
                  (paddr >= 12'h040 && paddr < 12'h088));
  // counts output clock rises seen while the marker stands
  assign markRise_next = frameMarker ? markRise_reg + {2'h0, serialClk & ~sclkPrev_reg} : 3'h0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkPrev_reg <= 1'b0;
      markRise_reg <= 3'h0;
    end else begin
      sclkPrev_reg <= serialClk;
      markRise_reg <= markRise_next;
    end
  end
  // ====
  // properties
  sequence apbAccess;
    psel && penable && pready;
  endsequence
  sequence ctrlWrite;
    apbAccess ##0 (pwrite && paddr == 12'h000);
  endsequence
  sequence biasWrite;
    apbAccess ##0 (pwrite && paddr == 12'h040);
  endsequence
  a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready && ce |=> !pready) else $error("ready too long");
  a_error_decode: assert property (pready |-> pslverr == !mapped) else $error("bad error flag");
  a_read_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  a_clock_running: assert property (ce |-> ##[1:3] ($changed(serialClk) || !ce))
    else $error("output clock stopped");
  a_marker_four: assert property ($fell(frameMarker) |-> markRise_reg == 3'h4)
    else $error("marker length wrong");
  a_marker_align: assert property ($changed(frameMarker) |-> $fell(serialClk))
    else $error("marker off clock edge");
  a_data_align: assert property ($changed({serialLineZero, serialLineOne}) |-> $fell(serialClk))
    else $error("data off clock edge");
  a_bias_follow: assert property (biasWrite |-> ##2 biasCodes[7:0] == $past(pwdata[7:0], 2))
    else $error("bias code not applied");
  a_test_enable: assert property (ctrlWrite |-> ##2 analogueTestEn == $past(pwdata[3], 2))
    else $error("test enable wrong");
endmodule // spfs_checker
bind spfs_serializer spfs_checker u_chk (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serialClk(serialClk),
  .serialLineZero(serialLineZero), .serialLineOne(serialLineOne),
  .frameMarker(frameMarker), .biasCodes(biasCodes), .analogueTestEn(analogueTestEn));
`default_nettype wire

// ### test/tb.sv
// self-checking bench of the sparse pixel frame serializer
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int FRAME = 2000;
  logic         clk, rst, ce, psel, penable, pwrite, startIn, hitValid;
  logic         pready, pslverr, sclk, l0, l1, mk, ate, er;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, sw, ew;
  logic [15:0]  hitWord;
  logic [15:0]  hits [0:3];
  logic [15:0]  wz [0:15];
  logic [15:0]  wo [0:15];
  logic [4:0]   wc;
  logic [7:0]   fc;
  logic [143:0] bias;
  logic [3:0]   clamp;
  integer       seed, miscompares, comparisons, cycles, i, k, n, t, f0;
  spfs_serializer #(.FRAME_CYCLES(FRAME)) dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .startIn(startIn), .hitValid(hitValid),
    .hitWord(hitWord), .serialClk(sclk), .serialLineZero(l0), .serialLineOne(l1),
    .frameMarker(mk), .biasCodes(bias), .pixelClampDac(clamp), .analogueTestEn(ate));
  spfs_rx_model rx (.serialClk(sclk), .serialLineZero(l0), .serialLineOne(l1),
    .frameMarker(mk), .wordsZero(wz), .wordsOne(wo), .wordCount(wc), .frameCount(fc));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ====
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected 32-bit slot j of a frame carrying nh hits, after a counter restart
  function automatic logic [31:0] pair(input integer j, input integer nh);
    integer L;
    L = (nh + 1) / 2;
    if (j == 0) return sw;
    if (j == 1) return 32'h0;
    if (j == 2) return {L[15:0], L[15:0]};
    if (j < 3 + L) return {(2 * j - 5 < nh) ? hits[2 * j - 5] : 16'h0, hits[2 * j - 6]};
    if (j == 3 + L) return ew;
    return 32'h0;
  endfunction
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  // ====
  // main sequence
  initial begin
    seed = 52;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    {rst, ce, psel, penable, pwrite, startIn, hitValid} = 7'h60;
    paddr = 12'h0;
    pwdata = 32'h0;
    hitWord = 16'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    sw = $random(seed);
    ew = $random(seed);
    apb(1'b1, 12'h004, sw);
    apb(1'b1, 12'h008, ew);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, sw);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, ew);
    apb(1'b0, 12'h020, 32'h0);
    check({rd[30:0], er}, 32'h1);
    for (i = 0; i < 18; i += 17) begin
      t = $random(seed);
      apb(1'b1, 12'h040 + 12'(4 * i), t);
      apb(1'b0, 12'h040 + 12'(4 * i), 32'h0);
      check(rd, {24'h0, t[7:0]});
      check(bias[8 * i +: 8], t[7:0]);
    end
    apb(1'b1, 12'h014, t);
    apb(1'b0, 12'h014, 32'h0);
    check({rd[27:0], clamp}, {t[3:0], t[3:0]});
    apb(1'b1, 12'h000, 32'h8);
    repeat (2) @(posedge clk);
    check(ate, 1'b1);
    // every rate and line setting, with as many hits as its index
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, i);
      startIn <= 1'b1;
      repeat (16) @(posedge clk);
      startIn <= 1'b0;
      apb(1'b1, 12'h000, i | 4);
      apb(1'b1, 12'h000, i);
      check(ate, 1'b0);
      for (k = 0; k < i; k++) begin
        hits[k] = $random(seed);
        @(posedge clk);
        hitValid <= 1'b1;
        hitWord <= hits[k];
      end
      @(posedge clk);
      hitValid <= 1'b0;
      f0 = fc;
      n = (5 + (i + 1) / 2) * (i[1] ? 1 : 2);
      while ((fc == f0[7:0] || wc < n) && cycles < 38000) @(posedge clk);
      for (k = 0; k < n; k++) begin
        rd = pair(i[1] ? k : k / 2, i);
        check({wo[k], wz[k]}, i[1] ? rd : {k[0] ? rd[31:16] : rd[15:0], 16'h0});
      end
      if (!i[1]) check(wo[4] + wo[5], 2 * ((i + 1) / 2));
      // one boundary since the restart has been counted
      apb(1'b0, 12'h00c, 32'h0);
      check(rd, 32'h1);
      @(posedge sclk);
      t = $time;
      @(posedge sclk);
      check($time - t, i[0] ? 16 : 32);
    end
    // clock enable low must freeze the link outputs
    ce <= 1'b0;
    @(posedge clk);
    f0 = {sclk, l0, l1, mk};
    repeat (8) @(posedge clk);
    check({sclk, l0, l1, mk}, f0[3:0]);
    ce <= 1'b1;
    complete_run();
  end
endmodule // tb
`default_nettype wire
